// [rtl/charge_temp_defs.svh]
`ifndef CHARGE_TEMP_DEFS_SVH
`define CHARGE_TEMP_DEFS_SVH

// register offsets
`define CHARGE_HOT_THRESHOLD_LOW_OFS    8'h30
`define CHARGE_HOT_THRESHOLD_HIGH_OFS   8'h31
`define CHARGE_HOT_RECOVERY_LOW_OFS     8'h32
`define CHARGE_HOT_RECOVERY_HIGH_OFS    8'h33
`define CHARGE_COLD_THRESHOLD_LOW_OFS   8'h34
`define CHARGE_COLD_THRESHOLD_HIGH_OFS  8'h35
`define CHARGE_COLD_RECOVERY_LOW_OFS    8'h36
`define CHARGE_COLD_RECOVERY_HIGH_OFS   8'h37

// reset values
`define CHARGE_HOT_THRESHOLD_LOW_RST    8'hb6
`define CHARGE_HOT_THRESHOLD_HIGH_RST   8'h04
`define CHARGE_HOT_RECOVERY_LOW_RST     8'h3e
`define CHARGE_HOT_RECOVERY_HIGH_RST    8'h05
`define CHARGE_COLD_THRESHOLD_LOW_RST   8'hf2
`define CHARGE_COLD_THRESHOLD_HIGH_RST  8'h0b
`define CHARGE_COLD_RECOVERY_LOW_RST    8'h93
`define CHARGE_COLD_RECOVERY_HIGH_RST   8'h0a

// high byte holds threshold bits 11..8 in its low nibble
`define HIGH_NIBBLE_MASK                8'h0f

// status bit positions within the fault status byte
`define CHARGE_HOT_FAULT_BIT            6
`define CHARGE_COLD_FAULT_BIT           7

`endif

// [rtl/charge_temp_pkg.sv]
package charge_temp_pkg;

  // one register access from the serial front end
  typedef struct packed {
    logic       write_strobe;
    logic [7:0] address;
    logic [7:0] write_data;
  } reg_access_type;

  // pair of digitized thermistor readings with a fresh marker
  typedef struct packed {
    logic        valid;
    logic [11:0] therm_a;
    logic [11:0] therm_b;
  } therm_sample_type;

  // the four 12-bit charge temperature thresholds
  typedef struct packed {
    logic [11:0] hot_threshold;
    logic [11:0] hot_recovery;
    logic [11:0] cold_threshold;
    logic [11:0] cold_recovery;
  } threshold_set_type;

  // fault flag states
  typedef enum logic [1:0] {
    flag_clear = 2'b01,
    flag_set   = 2'b10
  } flag_state_type;

endpackage : charge_temp_pkg

// [rtl/charge_temperature_protection.sv]
// Summary of operation
// R1 - hot threshold is low byte bits 7..0 plus next register's low nibble as 11..8.
// R2 - software writes zero to high-byte upper nibble and ignores it on read.
// R3 - hot recovery threshold assembled from low byte and next register's low nibble.
// R4 - cold threshold assembled from low byte and next register's low nibble.
// R5 - cold recovery threshold assembled from low byte and next register's low nibble.
// R6 - either thermistor below hot threshold sets hot fault flag, status bit 6.
// R7 - hot fault in device mode turns off charge, precharge drives and balancing.
// R8 - in host mode the microcontroller handles a hot fault itself.
// R9 - hot flag clears only if set and both thermistors exceed hot recovery.
// R10 - hot fault clear in device mode re-enables drives and balancing if permitted.
// R11 - software sets hot recovery above hot threshold.
// R12 - either thermistor above cold threshold sets cold fault flag, status bit 7.
// R13 - cold fault in device mode turns off charge, precharge drives and balancing.
// R14 - in host mode the microcontroller handles a cold fault itself.
// R15 - cold flag clears only if set and both thermistors below cold recovery.
// R16 - cold fault clear in device mode re-enables drives and balancing if permitted.
// R17 - in host mode the microcontroller restores charge and balancing after clear.
// R18 - software sets cold recovery below cold threshold.
// R19 - codes equal volts times 4095 over 1.8, same scale as readings.
// R20 - comparisons run on each fresh reading pair; flags hold between events.
`timescale 1ns/1ps
`include "charge_temp_defs.svh"

module charge_temperature_protection
(
  input  wire logic                              clock,
  input  wire logic                              rst,
  input  wire charge_temp_pkg::reg_access_type   reg_access,
  output logic [7:0]                             read_data,
  input  wire charge_temp_pkg::therm_sample_type therm_sample,
  input  wire logic                              host_controls_balancing,
  input  wire logic                              host_charge_switch,
  input  wire logic                              charge_permitted,
  input  wire logic                              balance_permitted,
  output logic                                   charge_hot_fault_flag,
  output logic                                   charge_cold_fault_flag,
  output logic [7:0]                             fault_status,
  output logic                                   charge_switch_drive,
  output logic                                   precharge_switch_drive,
  output logic                                   balance_enable
);
  import charge_temp_pkg::*;

  // ---------------------------------------------------------------
  // threshold registers
  // ---------------------------------------------------------------
  logic [7:0] hot_thr_low_reg,   hot_thr_low_next;
  logic [7:0] hot_thr_high_reg,  hot_thr_high_next;
  logic [7:0] hot_rec_low_reg,   hot_rec_low_next;
  logic [7:0] hot_rec_high_reg,  hot_rec_high_next;
  logic [7:0] cold_thr_low_reg,  cold_thr_low_next;
  logic [7:0] cold_thr_high_reg, cold_thr_high_next;
  logic [7:0] cold_rec_low_reg,  cold_rec_low_next;
  logic [7:0] cold_rec_high_reg, cold_rec_high_next;
  threshold_set_type thresholds;

  // join a low byte and the low nibble of its partner into one code
  function automatic logic [11:0] join_code(input logic [7:0] low, input logic [7:0] high);
    join_code = {high[3:0], low};
  endfunction : join_code

  // true when an access points at the given offset, read or write
  function automatic logic addressed(input reg_access_type acc, input logic [7:0] ofs);
    addressed = (acc.address == ofs);
  endfunction : addressed

  // true when an access writes the given offset
  function automatic logic hits(input reg_access_type acc, input logic [7:0] ofs);
    hits = acc.write_strobe && addressed(acc, ofs);
  endfunction : hits

  // full bytes are stored so a nonzero upper nibble reads back as written;
  // only the low nibble takes part in the compare [R2]
  always_comb
  begin
    hot_thr_low_next   = hot_thr_low_reg;
    hot_thr_high_next  = hot_thr_high_reg;
    hot_rec_low_next   = hot_rec_low_reg;
    hot_rec_high_next  = hot_rec_high_reg;
    cold_thr_low_next  = cold_thr_low_reg;
    cold_thr_high_next = cold_thr_high_reg;
    cold_rec_low_next  = cold_rec_low_reg;
    cold_rec_high_next = cold_rec_high_reg;
    if (hits(reg_access, `CHARGE_HOT_THRESHOLD_LOW_OFS))
      hot_thr_low_next = reg_access.write_data;
    else if (hits(reg_access, `CHARGE_HOT_THRESHOLD_HIGH_OFS))
      hot_thr_high_next = reg_access.write_data;
    else if (hits(reg_access, `CHARGE_HOT_RECOVERY_LOW_OFS))
      hot_rec_low_next = reg_access.write_data;
    else if (hits(reg_access, `CHARGE_HOT_RECOVERY_HIGH_OFS))
      hot_rec_high_next = reg_access.write_data;
    else if (hits(reg_access, `CHARGE_COLD_THRESHOLD_LOW_OFS))
      cold_thr_low_next = reg_access.write_data;
    else if (hits(reg_access, `CHARGE_COLD_THRESHOLD_HIGH_OFS))
      cold_thr_high_next = reg_access.write_data;
    else if (hits(reg_access, `CHARGE_COLD_RECOVERY_LOW_OFS))
      cold_rec_low_next = reg_access.write_data;
    else if (hits(reg_access, `CHARGE_COLD_RECOVERY_HIGH_OFS))
      cold_rec_high_next = reg_access.write_data;
  end

  // register the threshold bytes
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      hot_thr_low_reg   <= `CHARGE_HOT_THRESHOLD_LOW_RST;
      hot_thr_high_reg  <= `CHARGE_HOT_THRESHOLD_HIGH_RST;
      hot_rec_low_reg   <= `CHARGE_HOT_RECOVERY_LOW_RST;
      hot_rec_high_reg  <= `CHARGE_HOT_RECOVERY_HIGH_RST;
      cold_thr_low_reg  <= `CHARGE_COLD_THRESHOLD_LOW_RST;
      cold_thr_high_reg <= `CHARGE_COLD_THRESHOLD_HIGH_RST;
      cold_rec_low_reg  <= `CHARGE_COLD_RECOVERY_LOW_RST;
      cold_rec_high_reg <= `CHARGE_COLD_RECOVERY_HIGH_RST;
    end
    else
    begin
      hot_thr_low_reg   <= hot_thr_low_next;
      hot_thr_high_reg  <= hot_thr_high_next;
      hot_rec_low_reg   <= hot_rec_low_next;
      hot_rec_high_reg  <= hot_rec_high_next;
      cold_thr_low_reg  <= cold_thr_low_next;
      cold_thr_high_reg <= cold_thr_high_next;
      cold_rec_low_reg  <= cold_rec_low_next;
      cold_rec_high_reg <= cold_rec_high_next;
    end
  end

  // ---------------------------------------------------------------
  // threshold assembly
  // ---------------------------------------------------------------
  // codes share the reading scale, so compares are plain unsigned [R19]
  // one process drives the whole set, so the struct has a single driver
  always_comb
  begin
    thresholds.hot_threshold  = join_code(hot_thr_low_reg, hot_thr_high_reg);    // [R1]
    thresholds.hot_recovery   = join_code(hot_rec_low_reg, hot_rec_high_reg);    // [R3]
    thresholds.cold_threshold = join_code(cold_thr_low_reg, cold_thr_high_reg);  // [R4]
    thresholds.cold_recovery  = join_code(cold_rec_low_reg, cold_rec_high_reg);  // [R5]
  end

  // ---------------------------------------------------------------
  // read-back
  // ---------------------------------------------------------------
  logic [7:0] read_data_reg, read_data_next;
  logic [7:0] status_reg, status_next;

  // address decode for reads; unmapped offsets return zero
  always_comb
  begin
    if (addressed(reg_access, `CHARGE_HOT_THRESHOLD_LOW_OFS))
      read_data_next = hot_thr_low_reg;
    else if (addressed(reg_access, `CHARGE_HOT_THRESHOLD_HIGH_OFS))
      read_data_next = hot_thr_high_reg;
    else if (addressed(reg_access, `CHARGE_HOT_RECOVERY_LOW_OFS))
      read_data_next = hot_rec_low_reg;
    else if (addressed(reg_access, `CHARGE_HOT_RECOVERY_HIGH_OFS))
      read_data_next = hot_rec_high_reg;
    else if (addressed(reg_access, `CHARGE_COLD_THRESHOLD_LOW_OFS))
      read_data_next = cold_thr_low_reg;
    else if (addressed(reg_access, `CHARGE_COLD_THRESHOLD_HIGH_OFS))
      read_data_next = cold_thr_high_reg;
    else if (addressed(reg_access, `CHARGE_COLD_RECOVERY_LOW_OFS))
      read_data_next = cold_rec_low_reg;
    else if (addressed(reg_access, `CHARGE_COLD_RECOVERY_HIGH_OFS))
      read_data_next = cold_rec_high_reg;
    else
      read_data_next = 8'h00;
  end

  // the byte is registered so read data never glitches while the
  // address settles; the cost is one cycle of read latency
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      read_data_reg <= 8'h00;
    else
      read_data_reg <= read_data_next;
  end

  // ---------------------------------------------------------------
  // fault flags
  // ---------------------------------------------------------------
  flag_state_type hot_state_reg, hot_state_next;
  flag_state_type cold_state_reg, cold_state_next;
  logic hot_set_cond, hot_clear_cond, cold_set_cond, cold_clear_cond;

  // either input can raise a fault, both must agree to clear it
  always_comb
  begin
    hot_set_cond    = (therm_sample.therm_a < thresholds.hot_threshold)
                   || (therm_sample.therm_b < thresholds.hot_threshold);     // [R6]
    hot_clear_cond  = (therm_sample.therm_a > thresholds.hot_recovery)
                   && (therm_sample.therm_b > thresholds.hot_recovery);      // [R9]
    cold_set_cond   = (therm_sample.therm_a > thresholds.cold_threshold)
                   || (therm_sample.therm_b > thresholds.cold_threshold);    // [R12]
    cold_clear_cond = (therm_sample.therm_a < thresholds.cold_recovery)
                   && (therm_sample.therm_b < thresholds.cold_recovery);     // [R15]
  end

  // evaluated only on fresh samples; set wins if a misprogrammed
  // window makes set and clear true together
  always_comb
  begin
    hot_state_next  = hot_state_reg;
    cold_state_next = cold_state_reg;
    if (therm_sample.valid)                                                   // [R20]
    begin
      case (hot_state_reg)
        flag_clear:
          if (hot_set_cond)
            hot_state_next = flag_set;                                        // [R6]
        flag_set:
          if (hot_clear_cond && !hot_set_cond)
            hot_state_next = flag_clear;                                      // [R9]
        default:
          hot_state_next = flag_clear;
      endcase
      case (cold_state_reg)
        flag_clear:
          if (cold_set_cond)
            cold_state_next = flag_set;                                       // [R12]
        flag_set:
          if (cold_clear_cond && !cold_set_cond)
            cold_state_next = flag_clear;                                     // [R15]
        default:
          cold_state_next = flag_clear;
      endcase
    end
  end

  // register the flag states; a converter that stops sending samples
  // freezes both flags, so the drives keep their last gating until
  // readings resume
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      hot_state_reg  <= flag_clear;
      cold_state_reg <= flag_clear;
    end
    else
    begin
      hot_state_reg  <= hot_state_next;
      cold_state_reg <= cold_state_next;
    end
  end

  // ---------------------------------------------------------------
  // charge path control
  // ---------------------------------------------------------------
  logic charge_drive_reg, charge_drive_next;
  logic precharge_drive_reg, precharge_drive_next;
  logic balance_reg, balance_next;
  logic any_fault;

  // in device mode faults gate the drives; in host mode the charge
  // switch follows the microcontroller's control bit instead
  // limitation: host mode never gates on a flag, a silent host keeps charging
  always_comb
  begin
    any_fault = (hot_state_next == flag_set) || (cold_state_next == flag_set);
    if (!host_controls_balancing)
    begin
      charge_drive_next    = charge_permitted && !any_fault;      // [R7] [R10] [R13] [R16]
      precharge_drive_next = charge_permitted && !any_fault;      // [R7] [R10] [R13] [R16]
      balance_next         = balance_permitted && !any_fault;     // [R7] [R10] [R13] [R16]
    end
    else
    begin
      charge_drive_next    = host_charge_switch && charge_permitted;  // [R8] [R14] [R17]
      precharge_drive_next = host_charge_switch && charge_permitted;  // [R8] [R14] [R17]
      balance_next         = balance_permitted;                       // [R8] [R14] [R17]
    end
  end

  // register the drives; all stay off in reset so the charge path
  // cannot open before the thresholds hold their defaults
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      charge_drive_reg    <= 1'b0;
      precharge_drive_reg <= 1'b0;
      balance_reg         <= 1'b0;
    end
    else
    begin
      charge_drive_reg    <= charge_drive_next;
      precharge_drive_reg <= precharge_drive_next;
      balance_reg         <= balance_next;
    end
  end

  // ---------------------------------------------------------------
  // fault status byte
  // ---------------------------------------------------------------
  // built from the next flag states so the byte and the flags change on
  // the same edge; the unused bits read as zero
  always_comb
  begin
    status_next                         = 8'h00;
    status_next[`CHARGE_HOT_FAULT_BIT]  = (hot_state_next == flag_set);   // [R6]
    status_next[`CHARGE_COLD_FAULT_BIT] = (cold_state_next == flag_set);  // [R12]
  end

  // register the status byte
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      status_reg <= 8'h00;
    else
      status_reg <= status_next;
  end

  // outputs straight from flip-flops
  assign charge_hot_fault_flag  = (hot_state_reg == flag_set);
  assign charge_cold_fault_flag = (cold_state_reg == flag_set);
  assign fault_status           = status_reg;
  assign charge_switch_drive    = charge_drive_reg;
  assign precharge_switch_drive = precharge_drive_reg;
  assign balance_enable         = balance_reg;
  assign read_data              = read_data_reg;

endmodule : charge_temperature_protection

// [bench/charge_temperature_protection_properties.sv]
`timescale 1ns/1ps
module charge_temperature_protection_properties
(
  input wire logic                              clock,
  input wire logic                              rst,
  input wire charge_temp_pkg::reg_access_type   reg_access,
  input wire logic [7:0]                        read_data,
  input wire charge_temp_pkg::therm_sample_type therm_sample,
  input wire logic                              host_controls_balancing,
  input wire logic                              host_charge_switch,
  input wire logic                              charge_permitted,
  input wire logic                              balance_permitted,
  input wire logic                              charge_hot_fault_flag,
  input wire logic                              charge_cold_fault_flag,
  input wire logic [7:0]                        fault_status,
  input wire logic                              charge_switch_drive,
  input wire logic                              precharge_switch_drive,
  input wire logic                              balance_enable
);
  import charge_temp_pkg::*;
  // ----------------------------
  // fault flags and charge path
  // ----------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_status_mirror: assert property (
    fault_status == {charge_cold_fault_flag, charge_hot_fault_flag, 6'h00})
    else $error("status byte disagrees with fault flags");
  a_hot_gates: assert property (
    charge_hot_fault_flag && !$past(host_controls_balancing) |->
    !charge_switch_drive && !precharge_switch_drive && !balance_enable)
    else $error("charge path on during hot fault");
  a_cold_gates: assert property (
    charge_cold_fault_flag && !$past(host_controls_balancing) |->
    !charge_switch_drive && !precharge_switch_drive && !balance_enable)
    else $error("charge path on during cold fault");
  a_hot_holds: assert property (
    !$past(therm_sample.valid) |-> $stable(charge_hot_fault_flag))
    else $error("hot flag moved without a sample");
  a_cold_holds: assert property (
    !$past(therm_sample.valid) |-> $stable(charge_cold_fault_flag))
    else $error("cold flag moved without a sample");
  // the edge right after reset release still shows reset values, so skip it
  a_charge_restore: assert property (
    !$past(rst) && !charge_hot_fault_flag && !charge_cold_fault_flag &&
    !$past(host_controls_balancing) && $past(charge_permitted) |->
    charge_switch_drive && precharge_switch_drive)
    else $error("charge path not restored");
  a_balance_restore: assert property (
    !$past(rst) && !charge_hot_fault_flag && !charge_cold_fault_flag &&
    !$past(host_controls_balancing) && $past(balance_permitted) |-> balance_enable)
    else $error("balancing not restored");
  a_host_follow: assert property (
    !$past(rst) && $past(host_controls_balancing) |->
    charge_switch_drive == ($past(host_charge_switch) && $past(charge_permitted)) &&
    balance_enable == $past(balance_permitted))
    else $error("host mode drives do not follow host");
endmodule : charge_temperature_protection_properties

bind charge_temperature_protection charge_temperature_protection_properties checks (
  .clock(clock), .rst(rst), .reg_access(reg_access), .read_data(read_data),
  .therm_sample(therm_sample), .host_controls_balancing(host_controls_balancing),
  .host_charge_switch(host_charge_switch), .charge_permitted(charge_permitted),
  .balance_permitted(balance_permitted), .charge_hot_fault_flag(charge_hot_fault_flag),
  .charge_cold_fault_flag(charge_cold_fault_flag), .fault_status(fault_status),
  .charge_switch_drive(charge_switch_drive), .precharge_switch_drive(precharge_switch_drive),
  .balance_enable(balance_enable));

// [bench/therm_host_model.sv]
`timescale 1ns/1ps
module therm_host_model
(
  input  wire logic                         clock,
  input  wire logic                         rst,
  input  wire logic [11:0]                  level_a,
  input  wire logic [11:0]                  level_b,
  input  wire logic                         hot_fault,
  input  wire logic                         cold_fault,
  output charge_temp_pkg::therm_sample_type sample,
  output logic                              host_switch
);
  import charge_temp_pkg::*;
  logic [1:0] phase_reg;
  logic       fresh;
  // converter finishes a pair every fourth cycle; host reacts one cycle late
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      phase_reg   <= 2'h0;
      host_switch <= 1'b0;
    end
    else
    begin
      phase_reg   <= phase_reg + 2'h1;
      host_switch <= !(hot_fault || cold_fault);
    end
  end
  // stale lines carry the inverse so an unqualified sample is visibly wrong
  assign fresh          = (phase_reg == 2'h3) && !rst;
  assign sample = '{valid:   fresh,
                    therm_a: fresh ? level_a : ~level_a,
                    therm_b: fresh ? level_b : ~level_b};
endmodule : therm_host_model

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import charge_temp_pkg::*;
  logic             clock, rst, mode, host_sw, chg_ok, bal_ok, hot, cold, chg, pre, bal;
  logic [7:0]       read_data, fault_status;
  logic [11:0]      lvl_a, lvl_b;
  reg_access_type   acc;
  therm_sample_type smp;
  int               failures, n_checks;
  logic [7:0] dflt [8] = '{8'hb6, 8'h04, 8'h3e, 8'h05, 8'hf2, 8'h0b, 8'h93, 8'h0a};

  charge_temperature_protection uut (.clock(clock), .rst(rst), .reg_access(acc),
    .read_data(read_data), .therm_sample(smp), .host_controls_balancing(mode),
    .host_charge_switch(host_sw), .charge_permitted(chg_ok), .balance_permitted(bal_ok),
    .charge_hot_fault_flag(hot), .charge_cold_fault_flag(cold), .fault_status(fault_status),
    .charge_switch_drive(chg), .precharge_switch_drive(pre), .balance_enable(bal));
  therm_host_model partner (.clock(clock), .rst(rst), .level_a(lvl_a), .level_b(lvl_b),
    .hot_fault(hot), .cold_fault(cold), .sample(smp), .host_switch(host_sw));

  // ----------------
  // tasks
  // ----------------
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    acc <= '{1'b1, a, d};
    @(posedge clock);
    acc.write_strobe <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    acc.address <= a;
    @(posedge clock);
    @(negedge clock);
    cmp(read_data, e);
  endtask : rd
  // eight cycles cover two conversions plus the one-cycle host reaction
  task automatic state(input logic [11:0] a, b, input logic [7:0] st, input logic [2:0] dr);
    @(posedge clock);
    lvl_a <= a;
    lvl_b <= b;
    repeat (8) @(posedge clock);
    @(negedge clock);
    cmp(fault_status, st);
    cmp({6'h00, cold, hot}, {6'h00, st[7], st[6]});
    cmp({5'h00, chg, pre, bal}, {5'h00, dr});
  endtask : state
  task automatic summarize;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  // ----------------
  // stimulus
  // ----------------
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // hang guard
  initial
  begin
    repeat (20000) @(posedge clock);
    failures++;
    summarize();
  end
  initial
  begin
    {rst, acc, mode, chg_ok, bal_ok, lvl_a, lvl_b} = {1'b1, 17'h0, 3'b011, 24'h700700};
    {failures, n_checks} = '0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd(8'h30 + i[7:0], dflt[i]);
    state(12'h700, 12'h700, 8'h00, 3'b111);
    wr(8'h30, 8'h00);
    wr(8'h31, 8'h01);
    rd(8'h31, 8'h01);
    wr(8'h38, 8'h55);
    rd(8'h38, 8'h00);
    rd(8'h30, 8'h00);
    wr(8'h32, 8'h00);
    wr(8'h33, 8'h06);
    state(12'h150, 12'h800, 8'h00, 3'b111);
    state(12'h100, 12'h800, 8'h00, 3'b111);
    state(12'h0ff, 12'h800, 8'h40, 3'b000);
    state(12'h700, 12'h600, 8'h40, 3'b000);
    state(12'h700, 12'h601, 8'h00, 3'b111);
    wr(8'h36, 8'h00);
    wr(8'h37, 8'h09);
    wr(8'h34, 8'h00);
    wr(8'h35, 8'h0a);
    state(12'ha00, 12'h700, 8'h00, 3'b111);
    state(12'ha01, 12'h700, 8'h80, 3'b000);
    state(12'h900, 12'h700, 8'h80, 3'b000);
    state(12'h8ff, 12'h700, 8'h00, 3'b111);
    state(12'h0ff, 12'ha01, 8'hc0, 3'b000);
    state(12'h700, 12'ha01, 8'h80, 3'b000);
    state(12'h700, 12'h700, 8'h00, 3'b111);
    @(posedge clock);
    chg_ok <= 1'b0;
    state(12'h700, 12'h700, 8'h00, 3'b001);
    @(posedge clock);
    {chg_ok, bal_ok} <= 2'b10;
    state(12'h700, 12'h700, 8'h00, 3'b110);
    @(posedge clock);
    {mode, bal_ok} <= 2'b11;
    state(12'h0ff, 12'h700, 8'h40, 3'b001);
    state(12'h700, 12'h700, 8'h00, 3'b111);
    state(12'ha01, 12'h700, 8'h80, 3'b001);
    state(12'h700, 12'h700, 8'h00, 3'b111);
    @(posedge clock);
    {mode, rst} <= 2'b01;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(8'h31, 8'h04);
    summarize();
  end
endmodule : testbench
